// *** design/pfs_consts.svh ***
`ifndef PFS_CONSTS_SVH
`define PFS_CONSTS_SVH
// Function
// - control word comes out of reset and boot as 0x82e37ef3
// - control word lives at offset 0x30, full 32-bit word access only
// - bit 26 clear lets a clock watchdog event reset; set suppresses it
// - bit 25 clear shuts power switches on clock loss; set does not
// - bit 24 clear enables switch shutdown on overtemperature; set disables
// - bit 14 clear enables power module shutdown on driver supply overvoltage
// - bit 8 clear shuts lin transmitter on main supply undervoltage
// - bit 7 clear turns bridge driver and charge pump off on overtemperature
// - bit 1 clear switches power devices off on a clock watchdog event
// - reserved fields always read their fixed pattern
// - overtemperature: stage off after 64 us, sleep after 1 ms
// - immediate stage off on overtemperature, no filter delay
// - overvoltage: sleep, stage and attenuators off, back on when it ends

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define ADDR_W 8
`define CTRL_OFS 8'h30
`define CTRL_RST 32'h82e3_7ef3
`define CTRL_WMASK 32'h0700_4182
`define STRB_ALL 4'hf

// ---------------------------------------------------------------
// control bit positions
// ---------------------------------------------------------------
`define BIT_WDT_RST 26
`define BIT_CLK_LOSS 25
`define BIT_OT_SW 24
`define BIT_OV 14
`define BIT_UV 8
`define BIT_FAIL 7
`define BIT_WDT_SD 1

// ---------------------------------------------------------------
// fault inputs and timing
// ---------------------------------------------------------------
`define FLT_N 5
`define FLT_WDT 4
`define FLT_LOSS 3
`define FLT_OT 2
`define FLT_OV 1
`define FLT_UV 0
`define PCLK_NS 50
`define OT_SHUT_NS 64000
`define OT_SLEEP_NS 1000000
`define OT_CNT_W 15
`define OT_SHUT_CYC ((`OT_SHUT_NS + `PCLK_NS - 1) / `PCLK_NS)
`define OT_SLEEP_CYC ((`OT_SLEEP_NS + `PCLK_NS - 1) / `PCLK_NS)

`endif

// *** design/pfs_pkg.sv ***
package pfs_pkg;
   typedef enum logic [1:0] {
      ot_idle,
      ot_filter,
      ot_shut,
      ot_sleep
   } ot_state_t;
endpackage

// *** design/power_fault_shutdown_control.sv ***
`timescale 1ns/1ns
`include "pfs_consts.svh"
module power_fault_shutdown_control #(
   parameter int unsigned OT_SLEEP_CYC = `OT_SLEEP_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // fault indications, asynchronous
   input wire logic clock_watchdog_event,
   input wire logic clock_loss,
   input wire logic overtemp_upper,
   input wire logic driver_supply_overvolt,
   input wire logic main_supply_undervolt,
   // shutdown and reset actions
   output logic clock_watchdog_reset,
   output logic clock_loss_shutdown,
   output logic power_device_off,
   output logic transceiver_shutdown,
   output logic bridge_driver_off,
   output logic charge_pump_off,
   output logic attenuator_off,
   output logic sleep_request
);

   localparam logic [31:0] WMASK = `CTRL_WMASK;
   localparam logic [31:0] RST = `CTRL_RST;
   localparam logic [`OT_CNT_W-1:0] SHUT_CNT = `OT_CNT_W'(`OT_SHUT_CYC);
   localparam logic [`OT_CNT_W-1:0] SLEEP_CNT = `OT_CNT_W'(OT_SLEEP_CYC);

   // ---------------------------------------------------------------
   // fault synchronisers
   // ---------------------------------------------------------------
   logic [`FLT_N-1:0] fault_raw;
   logic [`FLT_N-1:0] meta_q;
   logic [`FLT_N-1:0] sync_q;

   assign fault_raw[`FLT_WDT] = clock_watchdog_event;
   assign fault_raw[`FLT_LOSS] = clock_loss;
   assign fault_raw[`FLT_OT] = overtemp_upper;
   assign fault_raw[`FLT_OV] = driver_supply_overvolt;
   assign fault_raw[`FLT_UV] = main_supply_undervolt;

   // analog comparators are not on pclk, so two stages before use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= fault_raw;
         sync_q <= meta_q;
      end
   end

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   logic setup;
   logic hit;
   logic word_ok;
   logic wr_en;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   wire [31:0] ctrl_val;

   assign setup = psel && !penable;
   assign hit = (paddr == `CTRL_OFS);
   // partial writes are refused, not merged
   assign word_ok = !pwrite || (pstrb == `STRB_ALL);
   assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

   // one wait-free answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_q <= 1'b0;
      end else begin
         pslverr_q <= setup && !(hit && word_ok);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         prdata_q <= (hit && !pwrite) ? ctrl_val : 32'h0000_0000;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   for (genvar gi = 0; gi < 32; gi++) begin : g_ctrl
      if (WMASK[gi]) begin : g_rw
         logic bit_q;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               bit_q <= RST[gi];
            end else if (wr_en) begin
               bit_q <= pwdata[gi];
            end
         end
         assign ctrl_val[gi] = bit_q;
      end else begin : g_ro
         // reserved bits have no storage, so writes cannot touch them
         assign ctrl_val[gi] = RST[gi];
      end
   end

   // ---------------------------------------------------------------
   // gated fault terms
   // ---------------------------------------------------------------
   logic ot_armed;
   logic fail_now;
   logic ov_active;

   assign ot_armed = sync_q[`FLT_OT] && !ctrl_val[`BIT_OT_SW];
   assign fail_now = sync_q[`FLT_OT] && !ctrl_val[`BIT_FAIL];
   assign ov_active = sync_q[`FLT_OV] && !ctrl_val[`BIT_OV];

   // ---------------------------------------------------------------
   // overtemperature filter
   // ---------------------------------------------------------------
   pfs_pkg::ot_state_t ot_state_q;
   logic [`OT_CNT_W-1:0] ot_cnt_q;
   logic [`OT_CNT_W-1:0] ot_cnt_d;

   // saturate so a shortened or long parameter cannot wrap
   assign ot_cnt_d = (ot_cnt_q == '1) ? ot_cnt_q : ot_cnt_q + `OT_CNT_W'(1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ot_state_q <= pfs_pkg::ot_idle;
         ot_cnt_q <= '0;
      end else begin
         case (ot_state_q)
            pfs_pkg::ot_idle: begin
               if (ot_armed) begin
                  ot_state_q <= pfs_pkg::ot_filter;
                  ot_cnt_q <= `OT_CNT_W'(1);
               end
            end
            pfs_pkg::ot_filter: begin
               ot_cnt_q <= ot_cnt_d;
               if (!ot_armed) begin
                  ot_state_q <= pfs_pkg::ot_idle;
               end else if (ot_cnt_d >= SHUT_CNT) begin
                  ot_state_q <= pfs_pkg::ot_shut;
               end
            end
            pfs_pkg::ot_shut: begin
               ot_cnt_q <= ot_cnt_d;
               if (!ot_armed) begin
                  ot_state_q <= pfs_pkg::ot_idle;
               end else if (ot_cnt_d >= SLEEP_CNT) begin
                  ot_state_q <= pfs_pkg::ot_sleep;
               end
            end
            pfs_pkg::ot_sleep: begin
               if (!ot_armed) begin
                  ot_state_q <= pfs_pkg::ot_idle;
               end
            end
            default: begin
               ot_state_q <= pfs_pkg::ot_idle;
            end
         endcase
      end
   end

   logic ot_stage_off;
   assign ot_stage_off = (ot_state_q == pfs_pkg::ot_shut) || (ot_state_q == pfs_pkg::ot_sleep);

   // ---------------------------------------------------------------
   // clock watchdog actions
   // ---------------------------------------------------------------
   logic wdt_reset_q;
   logic wdt_off_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset_q <= 1'b0;
      end else begin
         wdt_reset_q <= sync_q[`FLT_WDT] && !ctrl_val[`BIT_WDT_RST];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_off_q <= 1'b0;
      end else begin
         wdt_off_q <= sync_q[`FLT_WDT] && !ctrl_val[`BIT_WDT_SD];
      end
   end

   assign clock_watchdog_reset = wdt_reset_q;
   assign power_device_off = wdt_off_q;

   // ---------------------------------------------------------------
   // clock loss and undervoltage actions
   // ---------------------------------------------------------------
   logic loss_off_q;
   logic uv_off_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loss_off_q <= 1'b0;
      end else begin
         loss_off_q <= sync_q[`FLT_LOSS] && !ctrl_val[`BIT_CLK_LOSS];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_off_q <= 1'b0;
      end else begin
         uv_off_q <= sync_q[`FLT_UV] && !ctrl_val[`BIT_UV];
      end
   end

   assign clock_loss_shutdown = loss_off_q;
   assign transceiver_shutdown = uv_off_q;

   // ---------------------------------------------------------------
   // power stage, attenuators and sleep
   // ---------------------------------------------------------------
   logic bridge_driver_off_q;
   logic cp_off_q;
   logic atten_off_q;
   logic sleep_q;

   // immediate path bypasses the filter entirely
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bridge_driver_off_q <= 1'b0;
         cp_off_q <= 1'b0;
      end else begin
         bridge_driver_off_q <= fail_now || ot_stage_off || ov_active;
         cp_off_q <= fail_now || ot_stage_off || ov_active;
      end
   end

   // released as soon as the overvoltage goes away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atten_off_q <= 1'b0;
      end else begin
         atten_off_q <= ov_active;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= (ot_state_q == pfs_pkg::ot_sleep) || ov_active;
      end
   end

   assign bridge_driver_off = bridge_driver_off_q;
   assign charge_pump_off = cp_off_q;
   assign attenuator_off = atten_off_q;
   assign sleep_request = sleep_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_ot_trip;
      sync_q[`FLT_OT] && !ctrl_val[`BIT_FAIL];
   endsequence

   sequence s_ov_trip;
      sync_q[`FLT_OV] && !ctrl_val[`BIT_OV];
   endsequence

   sequence s_bad_write;
      psel && penable && pready_q && pwrite && !(hit && word_ok);
   endsequence

   a_reset_value: assert property (
      $rose(presetn) |-> ctrl_val == RST)
      else $error("control word not at reset value");

   a_word_access: assert property (
      s_bad_write |-> pslverr ##1 $stable(ctrl_val))
      else $error("partial or unmapped write not refused");

   a_wdt_reset: assert property (
      sync_q[`FLT_WDT] |=> clock_watchdog_reset == !$past(ctrl_val[`BIT_WDT_RST]))
      else $error("watchdog reset gating wrong");

   a_loss_gate: assert property (
      clock_loss_shutdown |-> $past(sync_q[`FLT_LOSS] && !ctrl_val[`BIT_CLK_LOSS]))
      else $error("clock loss shutdown without cause");

   a_ot_disabled: assert property (
      ctrl_val[`BIT_OT_SW] |=> ot_state_q == pfs_pkg::ot_idle)
      else $error("overtemperature filter ran while disabled");

   a_ov_stage: assert property (
      s_ov_trip |=> bridge_driver_off && charge_pump_off)
      else $error("overvoltage did not stop stage");

   a_uv_gate: assert property (
      sync_q[`FLT_UV] |=> transceiver_shutdown == !$past(ctrl_val[`BIT_UV]))
      else $error("transceiver shutdown gating wrong");

   a_fail_stage: assert property (
      s_ot_trip |=> bridge_driver_off && charge_pump_off)
      else $error("immediate stage off missing");

   a_wdt_off: assert property (
      power_device_off |-> $past(sync_q[`FLT_WDT] && !ctrl_val[`BIT_WDT_SD]))
      else $error("power device off without cause");

   a_fixed_bits: assert property (
      (ctrl_val & ~WMASK) == (RST & ~WMASK))
      else $error("reserved bits changed");

   a_ot_shut_time: assert property (
      ot_stage_off |-> ot_cnt_q >= SHUT_CNT)
      else $error("stage off before filter time");

   a_ot_sleep_time: assert property (
      (ot_state_q == pfs_pkg::ot_sleep) |-> ot_cnt_q >= SLEEP_CNT)
      else $error("sleep before persistence time");

   a_no_delay: assert property (
      s_ot_trip ##1 s_ot_trip |-> bridge_driver_off)
      else $error("immediate path delayed");

   a_ov_release: assert property (
      (s_ov_trip |=> sleep_request && attenuator_off) and (!sync_q[`FLT_OV] |=> !attenuator_off))
      else $error("overvoltage shutdown or release wrong");

   a_ctrl_hold: assert property (
      !wr_en |=> $stable(ctrl_val))
      else $error("control word changed without write");

endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
`include "pfs_consts.svh"
module tb_top;
   // ---------------------------------------------------------------
   // clock, reset and design
   // ---------------------------------------------------------------
   // short sleep count keeps the run brief; still above the 1280-cycle stage delay
   localparam int unsigned SLEEP_CYC = 1400;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [`ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [4:0] flt = 5'h00;
   wire [7:0] outs;
   int errors = 0;
   int num_checks = 0;
   logic [31:0] model_q;
   logic [31:0] rd;
   logic er;
   logic [7:0] ex;

   always #25 pclk = ~pclk;

   power_fault_shutdown_control #(.OT_SLEEP_CYC(SLEEP_CYC)) uut (
      .pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr),
      .clock_watchdog_event(flt[`FLT_WDT]), .clock_loss(flt[`FLT_LOSS]),
      .overtemp_upper(flt[`FLT_OT]), .driver_supply_overvolt(flt[`FLT_OV]),
      .main_supply_undervolt(flt[`FLT_UV]),
      .clock_watchdog_reset(outs[7]), .clock_loss_shutdown(outs[6]),
      .power_device_off(outs[5]), .transceiver_shutdown(outs[4]),
      .bridge_driver_off(outs[3]), .charge_pump_off(outs[2]),
      .attenuator_off(outs[1]), .sleep_request(outs[0])
   );

   // ---------------------------------------------------------------
   // compare tasks and verdict
   // ---------------------------------------------------------------
   task automatic end_of_test();
      if (errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: error flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: actions %b expected %b", $time, got, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // apb master and behavioural model
   // ---------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n >= 20) begin
         errors++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // only a mapped full-word write reaches the writable bits
      if (w && a == `CTRL_OFS && s == `STRB_ALL) begin
         model_q = (model_q & ~`CTRL_WMASK) | (d & `CTRL_WMASK);
      end
   endtask

   function automatic logic [7:0] exp_act(input logic [31:0] c, input logic [4:0] f);
      logic ov;
      ov = f[`FLT_OV] & ~c[`BIT_OV];
      exp_act[7] = f[`FLT_WDT] & ~c[`BIT_WDT_RST];
      exp_act[6] = f[`FLT_LOSS] & ~c[`BIT_CLK_LOSS];
      exp_act[5] = f[`FLT_WDT] & ~c[`BIT_WDT_SD];
      exp_act[4] = f[`FLT_UV] & ~c[`BIT_UV];
      exp_act[3] = (f[`FLT_OT] & ~c[`BIT_FAIL]) | ov;
      exp_act[2] = exp_act[3];
      exp_act[1] = ov;
      exp_act[0] = ov;
   endfunction

   task automatic do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      model_q = `CTRL_RST;
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(32'h10e83bcd));
      do_reset();
      apb(1'b0, `CTRL_OFS, 32'h0, `STRB_ALL, rd, er);
      chk32(rd, 32'h82e3_7ef3);
      chk1(er, 1'b0);
      // random words: reserved pattern stays, control bits follow
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, `CTRL_OFS, $urandom(), `STRB_ALL, rd, er);
         chk1(er, 1'b0);
         apb(1'b0, `CTRL_OFS, 32'h0, `STRB_ALL, rd, er);
         chk32(rd, model_q);
         chk32(rd & ~`CTRL_WMASK, 32'h82e3_7ef3 & ~`CTRL_WMASK);
      end
      // unmapped places and partial writes are refused, word unchanged
      apb(1'b0, 8'h34, 32'h0, `STRB_ALL, rd, er);
      chk1(er, 1'b1);
      chk32(rd, 32'h0000_0000);
      apb(1'b1, 8'h2c, 32'hffff_ffff, `STRB_ALL, rd, er);
      chk1(er, 1'b1);
      apb(1'b1, `CTRL_OFS, ~model_q, 4'h3, rd, er);
      chk1(er, 1'b1);
      apb(1'b0, `CTRL_OFS, 32'h0, `STRB_ALL, rd, er);
      chk32(rd, model_q);
      // fault gating with random control words and fault levels
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, `CTRL_OFS, $urandom(), `STRB_ALL, rd, er);
         @(posedge pclk);
         flt <= 5'($urandom());
         repeat (6) @(posedge pclk);
         ex = exp_act(model_q, flt);
         chk8(outs & 8'hf0, ex & 8'hf0);
         chk8(outs & 8'h0f, ex & 8'h0f);
         flt <= 5'h00;
         repeat (6) @(posedge pclk);
         chk8(outs, 8'h00);
      end
      // filtered overtemperature: stage off after 1280 cycles, then sleep
      apb(1'b1, `CTRL_OFS, 32'h82e3_7ef3, `STRB_ALL, rd, er);
      @(posedge pclk);
      flt <= 5'(1 << `FLT_OT);
      repeat (1270) @(posedge pclk);
      chk8(outs, 8'h00);
      repeat (30) @(posedge pclk);
      chk8(outs, 8'h0c);
      repeat (SLEEP_CYC - 1320) @(posedge pclk);
      chk8(outs, 8'h0c);
      repeat (40) @(posedge pclk);
      chk8(outs, 8'h0d);
      flt <= 5'h00;
      repeat (6) @(posedge pclk);
      chk8(outs, 8'h00);
      // same fault with the filtered path disabled gives no action
      apb(1'b1, `CTRL_OFS, 32'h83e3_7ef3, `STRB_ALL, rd, er);
      @(posedge pclk);
      flt <= 5'(1 << `FLT_OT);
      repeat (1400) @(posedge pclk);
      chk8(outs, 8'h00);
      flt <= 5'h00;
      // a second reset restores the boot value
      apb(1'b1, `CTRL_OFS, 32'h0000_0000, `STRB_ALL, rd, er);
      do_reset();
      apb(1'b0, `CTRL_OFS, 32'h0, `STRB_ALL, rd, er);
      chk32(rd, 32'h82e3_7ef3);
      end_of_test();
   end

   // a normal run ends well before this span; apb gives up on a hung handshake after 20 cycles
   initial begin
      #2000000;
      errors++;
      end_of_test();
   end
endmodule
